// ==== rtl/sitb_pkg.sv ====
package sitb_pkg;
  localparam int unsigned TRIM_W    = 8;
  localparam int unsigned NUM_TRIM  = 7;
  localparam int unsigned SLOT_W    = 3;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned IDX_W     = 10;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned TRIM_LSB  = 0;
  localparam int unsigned IDX_LSB   = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_A_SINGLE_FORE_PH90 = 10'h080;
  localparam logic [IDX_W-1:0] IDX_B_SINGLE_FORE_PH0  = 10'h081;
  localparam logic [IDX_W-1:0] IDX_A_SINGLE_BACK_PH90 = 10'h082;
  localparam logic [IDX_W-1:0] IDX_C_SINGLE_BACK_PH0  = 10'h083;
  localparam logic [IDX_W-1:0] IDX_C_SINGLE_BACK_PH90 = 10'h084;
  localparam logic [IDX_W-1:0] IDX_B_SINGLE_BACK_PH0  = 10'h085;
  localparam logic [IDX_W-1:0] IDX_A_DUAL_CHANNEL     = 10'h086;
  localparam logic [IDX_W-1:0] IDX_FIRST              = IDX_A_SINGLE_FORE_PH90;
  localparam logic [IDX_W-1:0] IDX_LAST               = IDX_A_DUAL_CHANNEL;

  // Storage slots, one per register, in index order
  localparam logic [SLOT_W-1:0] SLOT_A_FORE_PH90 = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_B_FORE_PH0  = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_A_BACK_PH90 = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_C_BACK_PH0  = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_C_BACK_PH90 = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_B_BACK_PH0  = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_A_DUAL      = 3'h6;

  localparam logic [TRIM_W-1:0] TRIM_IDLE  = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  typedef enum logic [1:0] {
    SITB_CORE_A = 2'h0,
    SITB_CORE_B = 2'h1,
    SITB_CORE_C = 2'h2
  } sitb_core_t;

  typedef enum logic [1:0] {
    SITB_SINGLE_FORE    = 2'b00,
    SITB_SINGLE_BACK_P0 = 2'b01,
    SITB_SINGLE_BACK_P90 = 2'b11,
    SITB_DUAL           = 2'b10
  } sitb_mode_t;

  typedef logic [NUM_TRIM-1:0][TRIM_W-1:0] sitb_trims_t;
endpackage

// ==== rtl/sitb_reg_if.sv ====
`timescale 1ns/100ps
interface sitb_reg_if;
  import sitb_pkg::*;
  logic                wr;
  logic [IDX_W-1:0]    idx;
  logic [TRIM_W-1:0]   wdata;
  logic [TRIM_W-1:0]   rdata;
  logic                hit;
  modport bus (output wr, idx, wdata, input rdata, hit);
  modport regs (input wr, idx, wdata, output rdata, hit);
endinterface

// ==== rtl/sitb_apb_slave.sv ====
`timescale 1ns/100ps
module sitb_apb_slave
  import sitb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  sitb_reg_if.bus                rif
);
  logic              pready_r,  pready_nxt;
  logic              pslverr_r, pslverr_nxt;
  logic [DATA_W-1:0] prdata_r,  prdata_nxt;
  logic              ok;

  // Misaligned or unmapped addresses answer with an error and change nothing
  assign ok        = rif.hit && (paddr[1:0] == 2'b00);
  assign rif.idx   = paddr[ADDR_W-1:IDX_LSB];
  assign rif.wdata = pwdata[TRIM_W-1:0];
  // Lane 0 holds the whole field; other lanes carry no storage
  assign rif.wr    = ce && psel && penable && pready_r && pwrite && ok && pstrb[0];

  // Answer is prepared in the setup cycle so PREADY leaves a flop
  always_comb begin
    pready_nxt  = psel && !penable;
    pslverr_nxt = psel && !penable && !ok;
    prdata_nxt  = RDATA_IDLE;
    if (psel && !penable && !pwrite && ok) begin
      prdata_nxt[TRIM_W-1:0] = rif.rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= RDATA_IDLE;
    end else if (ce) begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;
endmodule

// ==== rtl/sitb_core_sel.sv ====
`timescale 1ns/100ps
module sitb_core_sel
  import sitb_pkg::*;
#(
  parameter sitb_core_t CORE = SITB_CORE_A
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire sitb_mode_t        mode,
  input  wire sitb_trims_t       trims,
  output logic      [TRIM_W-1:0] delay,
  output logic                   active
);
  logic [TRIM_W-1:0] delay_r,  delay_nxt;
  logic              active_r, active_nxt;
  logic [SLOT_W-1:0] slot;

  always_comb begin
    slot       = SLOT_A_FORE_PH90;
    active_nxt = 1'b0;
    unique case (mode)
      SITB_SINGLE_FORE: begin
        if (CORE == SITB_CORE_A) begin
          slot       = SLOT_A_FORE_PH90;
          active_nxt = 1'b1;
        end else if (CORE == SITB_CORE_B) begin
          slot       = SLOT_B_FORE_PH0;
          active_nxt = 1'b1;
        end
      end
      SITB_SINGLE_BACK_P0: begin
        if (CORE == SITB_CORE_C) begin
          slot       = SLOT_C_BACK_PH0;
          active_nxt = 1'b1;
        end else if (CORE == SITB_CORE_B) begin
          slot       = SLOT_B_BACK_PH0;
          active_nxt = 1'b1;
        end
      end
      SITB_SINGLE_BACK_P90: begin
        if (CORE == SITB_CORE_A) begin
          slot       = SLOT_A_BACK_PH90;
          active_nxt = 1'b1;
        end else if (CORE == SITB_CORE_C) begin
          slot       = SLOT_C_BACK_PH90;
          active_nxt = 1'b1;
        end
      end
      SITB_DUAL: begin
        if (CORE == SITB_CORE_A) begin
          slot       = SLOT_A_DUAL;
          active_nxt = 1'b1;
        end
      end
    endcase
    delay_nxt = active_nxt ? trims[slot] : TRIM_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      delay_r  <= TRIM_IDLE;
      active_r <= 1'b0;
    end else if (ce) begin
      delay_r  <= delay_nxt;
      active_r <= active_nxt;
    end
  end

  assign delay  = delay_r;
  assign active = active_r;
endmodule

// ==== rtl/sitb_trim_bank.sv ====
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module sitb_trim_bank
  import sitb_pkg::*;
(
  input  wire logic                CLK_SYS,
  input  wire logic                RESET_N,
  input  wire logic                CE,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [ADDR_W-1:0]   PADDR,
  input  wire logic [DATA_W-1:0]   PWDATA,
  input  wire logic [3:0]          PSTRB,
  output logic      [DATA_W-1:0]   PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire sitb_trims_t         FACTORY_TRIM,
  input  wire logic                MODE_DUAL,
  input  wire logic                CAL_BACKGROUND,
  input  wire logic                CAL_PHASE90,
  output logic      [TRIM_W-1:0]   CORE_A_DELAY,
  output logic      [TRIM_W-1:0]   CORE_B_DELAY,
  output logic      [TRIM_W-1:0]   CORE_C_DELAY,
  output logic                     CORE_A_ACTIVE,
  output logic                     CORE_B_ACTIVE,
  output logic                     CORE_C_ACTIVE
);
  sitb_reg_if rif ();

  sitb_trims_t       trim_r, trim_nxt;
  logic              load_pend_r, load_pend_nxt;
  sitb_mode_t        mode_r, mode_nxt;
  logic [SLOT_W-1:0] wslot;
  logic              in_range;

  sitb_apb_slave u_apb (
    .clk     (CLK_SYS),
    .rst_n   (RESET_N),
    .ce      (CE),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .pstrb   (PSTRB),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .rif     (rif.bus)
  );

  assign in_range  = (rif.idx >= IDX_FIRST) && (rif.idx <= IDX_LAST);
  assign wslot     = SLOT_W'(rif.idx - IDX_FIRST);
  assign rif.hit   = in_range;
  assign rif.rdata = in_range ? trim_r[wslot] : TRIM_IDLE;

  // Factory values are caught by a clocked load after release, never by the reset branch
  always_comb begin
    trim_nxt      = trim_r;
    load_pend_nxt = 1'b0;
    if (load_pend_r) begin
      trim_nxt = FACTORY_TRIM;
    end else if (rif.wr) begin
      trim_nxt[wslot] = rif.wdata;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      trim_r      <= '0;
      load_pend_r <= 1'b1;
    end else if (CE) begin
      trim_r      <= trim_nxt;
      load_pend_r <= load_pend_nxt;
    end
  end

  // Dual-channel mode overrides the calibration choice; phase only matters in background
  always_comb begin
    if (MODE_DUAL) begin
      mode_nxt = SITB_DUAL;
    end else if (!CAL_BACKGROUND) begin
      mode_nxt = SITB_SINGLE_FORE;
    end else if (CAL_PHASE90) begin
      mode_nxt = SITB_SINGLE_BACK_P90;
    end else begin
      mode_nxt = SITB_SINGLE_BACK_P0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      mode_r <= SITB_SINGLE_FORE;
    end else if (CE) begin
      mode_r <= mode_nxt;
    end
  end

  sitb_core_sel #(.CORE(SITB_CORE_A)) u_core_a (
    .clk    (CLK_SYS),
    .rst_n  (RESET_N),
    .ce     (CE),
    .mode   (mode_r),
    .trims  (trim_r),
    .delay  (CORE_A_DELAY),
    .active (CORE_A_ACTIVE)
  );

  sitb_core_sel #(.CORE(SITB_CORE_B)) u_core_b (
    .clk    (CLK_SYS),
    .rst_n  (RESET_N),
    .ce     (CE),
    .mode   (mode_r),
    .trims  (trim_r),
    .delay  (CORE_B_DELAY),
    .active (CORE_B_ACTIVE)
  );

  sitb_core_sel #(.CORE(SITB_CORE_C)) u_core_c (
    .clk    (CLK_SYS),
    .rst_n  (RESET_N),
    .ce     (CE),
    .mode   (mode_r),
    .trims  (trim_r),
    .delay  (CORE_C_DELAY),
    .active (CORE_C_ACTIVE)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  // Write lands in its own slot one edge later, compared on the stored trim, not read over the bus
  write_lands_a : assert property (
    (rif.wr && !load_pend_r) |=> (trim_r[$past(wslot)] == $past(PWDATA[TRIM_W-1:0]))
  ) else $error("written trim value not stored");

  // Sampled reset keeps the release edge itself out of this check and the others below that sample RESET_N
  factory_load_a : assert property (
    (RESET_N && load_pend_r && CE) |=> (!load_pend_r && trim_r == $past(FACTORY_TRIM))
  ) else $error("factory trim not loaded after reset");

  write_isolated_a : assert property (
    (rif.wr && !load_pend_r && wslot != SLOT_A_DUAL) |=> $stable(trim_r[SLOT_A_DUAL])
  ) else $error("write disturbed another trim register");

  a_fore_sel_a : assert property (
    (RESET_N && CE && mode_r == SITB_SINGLE_FORE)
      |=> (CORE_A_ACTIVE && CORE_A_DELAY == $past(trim_r[SLOT_A_FORE_PH90]))
  ) else $error("core A foreground trim wrong");

  b_fore_sel_a : assert property (
    (RESET_N && CE && mode_r == SITB_SINGLE_FORE)
      |=> (CORE_B_DELAY == $past(trim_r[SLOT_B_FORE_PH0]) && !CORE_C_ACTIVE)
  ) else $error("core B foreground trim wrong");

  a_back_sel_a : assert property (
    (CE && mode_r == SITB_SINGLE_BACK_P90) |=> (CORE_A_DELAY == $past(trim_r[SLOT_A_BACK_PH90]) && !CORE_B_ACTIVE)
  ) else $error("core A background trim wrong");

  c_back0_sel_a : assert property (
    (CE && mode_r == SITB_SINGLE_BACK_P0) |=> (CORE_C_DELAY == $past(trim_r[SLOT_C_BACK_PH0]) && !CORE_A_ACTIVE)
  ) else $error("core C phase0 trim wrong");

  c_back90_sel_a : assert property (
    (CE && mode_r == SITB_SINGLE_BACK_P90) |=> (CORE_C_ACTIVE && CORE_C_DELAY == $past(trim_r[SLOT_C_BACK_PH90]))
  ) else $error("core C phase90 trim wrong");

  b_back_sel_a : assert property (
    (CE && mode_r == SITB_SINGLE_BACK_P0) |=> (CORE_B_ACTIVE && CORE_B_DELAY == $past(trim_r[SLOT_B_BACK_PH0]))
  ) else $error("core B background trim wrong");

  a_dual_sel_a : assert property (
    (CE && mode_r == SITB_DUAL) |=> (CORE_A_DELAY == $past(trim_r[SLOT_A_DUAL]) && !CORE_B_ACTIVE && !CORE_C_ACTIVE)
  ) else $error("core A dual-channel trim wrong");

  idle_core_zero_a : assert property (
    (!CORE_C_ACTIVE) |-> (CORE_C_DELAY == TRIM_IDLE)
  ) else $error("inactive core shows a delay");

  apb_answer_a : assert property (
    (CE && PSEL && !PENABLE) ##1 (CE && PSEL && PENABLE) |-> PREADY
  ) else $error("APB answer not after one wait-free cycle");

  idle_a_zero_a : assert property (
    (!CORE_A_ACTIVE) |-> (CORE_A_DELAY == TRIM_IDLE)
  ) else $error("inactive core A shows a delay");

  idle_b_zero_a : assert property (
    (!CORE_B_ACTIVE) |-> (CORE_B_DELAY == TRIM_IDLE)
  ) else $error("inactive core B shows a delay");

  read_data_a : assert property (
    (RESET_N && CE && PSEL && !PENABLE && !PWRITE && rif.hit && PADDR[1:0] == 2'h0)
      |=> (PREADY && !PSLVERR && PRDATA[TRIM_W-1:0] == $past(rif.rdata) && PRDATA[DATA_W-1:TRIM_W] == '0)
  ) else $error("read data is not the stored trim");

  refused_err_a : assert property (
    (RESET_N && CE && PSEL && !PENABLE && (!rif.hit || PADDR[1:0] != 2'h0))
      |=> (PREADY && PSLVERR && PRDATA == RDATA_IDLE)
  ) else $error("unmapped access not refused");

  // Strobe-less, misaligned and unmapped writes must leave every trim alone
  refused_write_a : assert property (
    (RESET_N && !load_pend_r && PSEL && PENABLE && PWRITE && (!rif.hit || PADDR[1:0] != 2'h0 || !PSTRB[0]))
      |=> $stable(trim_r)
  ) else $error("refused write changed a trim");

  mode_dual_a : assert property (
    (RESET_N && CE && MODE_DUAL) |=> (mode_r == SITB_DUAL)
  ) else $error("dual-channel mode not taken");

  mode_fore_a : assert property (
    (RESET_N && CE && !MODE_DUAL && !CAL_BACKGROUND) |=> (mode_r == SITB_SINGLE_FORE)
  ) else $error("foreground mode not taken");

  mode_back_a : assert property (
    (RESET_N && CE && !MODE_DUAL && CAL_BACKGROUND)
      |=> (mode_r == ($past(CAL_PHASE90) ? SITB_SINGLE_BACK_P90 : SITB_SINGLE_BACK_P0))
  ) else $error("background phase not taken");

  freeze_hold_a : assert property (
    (RESET_N && !CE) |=> ($stable(trim_r) && $stable(mode_r) && $stable(PREADY) && $stable(CORE_A_DELAY))
  ) else $error("state moved while clock enable low");

  dual_cover_c : cover property (mode_r == SITB_DUAL ##1 CORE_A_ACTIVE);
  phase_swap_c : cover property (mode_r == SITB_SINGLE_BACK_P0 ##[1:20] mode_r == SITB_SINGLE_BACK_P90);
  write_cover_c : cover property (rif.wr ##[1:8] (PSEL && !PENABLE && !PWRITE));
  error_cover_c : cover property (PREADY && PSLVERR);
  freeze_cover_c : cover property (!CE ##1 !CE);
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench
  import sitb_pkg::*;
;
  logic              clk_sys;
  logic              reset_n;
  logic              ce;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [3:0]        pstrb;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  sitb_trims_t       factory_trim;
  logic              mode_dual;
  logic              cal_background;
  logic              cal_phase90;
  logic [TRIM_W-1:0] core_delay [3];
  logic              core_active [3];
  logic [TRIM_W-1:0] cur [NUM_TRIM];
  int                miscompares = 0;
  int                compares    = 0;
  // Slot applied to cores A, B, C per mode (fore, back ph0, back ph90, dual); -1 means inactive
  int                slot_of [4][3] = '{'{0, 1, -1}, '{-1, 5, 3}, '{2, -1, 4}, '{6, -1, -1}};

  sitb_trim_bank u_sitb_trim_bank (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FACTORY_TRIM(factory_trim), .MODE_DUAL(mode_dual),
    .CAL_BACKGROUND(cal_background), .CAL_PHASE90(cal_phase90),
    .CORE_A_DELAY(core_delay[0]), .CORE_B_DELAY(core_delay[1]), .CORE_C_DELAY(core_delay[2]),
    .CORE_A_ACTIVE(core_active[0]), .CORE_B_ACTIVE(core_active[1]), .CORE_C_ACTIVE(core_active[2])
  );

  always #4 clk_sys = ~clk_sys;

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  function automatic logic [ADDR_W-1:0] addr_of(input int k);
    logic [IDX_W-1:0] ix;
    ix = IDX_FIRST + IDX_W'(k);
    return {ix, 2'b00};
  endfunction

  // Zero-wait slave still gets waited on with a bounded loop
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                     input logic [3:0] st, output logic [DATA_W-1:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("ERROR pready expected 1 seen %b", pready);
      miscompares++;
      end_sim();
    end
  endtask

  task automatic check_reg(input int k, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] rd;
    logic              err;
    apb(1'b0, addr_of(k), 32'h0000_0000, 4'h0, rd, err);
    check("prdata", rd, exp);
    check("pslverr", {31'h0, err}, 32'h0000_0000);
  endtask

  task automatic check_mode(input logic d, input logic bg, input logic p90, input int m);
    @(posedge clk_sys);
    mode_dual      <= d;
    cal_background <= bg;
    cal_phase90    <= p90;
    repeat (3) @(posedge clk_sys);
    #1;
    for (int c = 0; c < 3; c++) begin
      check("core_active", {31'h0, core_active[c]}, {31'h0, slot_of[m][c] >= 0});
      check("core_delay", {24'h0, core_delay[c]}, slot_of[m][c] >= 0 ? {24'h0, cur[slot_of[m][c]]} : 32'h0);
    end
  endtask

  task automatic test_factory();
    for (int k = 0; k < NUM_TRIM; k++) check_reg(k, {24'h0, cur[k]});
    $display("test_factory done");
  endtask

  task automatic test_write_read();
    logic [DATA_W-1:0] rd;
    logic              err;
    for (int k = 0; k < NUM_TRIM; k++) begin
      cur[k] = (k == 0) ? 8'hFF : (k == 6) ? 8'h00 : 8'h5A + TRIM_W'(k);
      apb(1'b1, addr_of(k), {24'hABCD12, cur[k]}, 4'hF, rd, err);
    end
    // Write with byte lane 0 off must leave the register alone
    apb(1'b1, addr_of(3), 32'h0000_0033, 4'hE, rd, err);
    for (int k = 0; k < NUM_TRIM; k++) check_reg(k, {24'h0, cur[k]});
    $display("test_write_read done");
  endtask

  task automatic test_errors();
    logic [DATA_W-1:0] rd;
    logic              err;
    logic [ADDR_W-1:0] bad [3] = '{12'h21C, 12'h1FC, 12'h205};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, bad[i], 32'h0000_00E7, 4'hF, rd, err);
      check("wr pslverr", {31'h0, err}, 32'h0000_0001);
      apb(1'b0, bad[i], 32'h0, 4'h0, rd, err);
      check("rd pslverr", {31'h0, err}, 32'h0000_0001);
      check("rd prdata", rd, 32'h0000_0000);
    end
    for (int k = 0; k < NUM_TRIM; k++) check_reg(k, {24'h0, cur[k]});
    $display("test_errors done");
  endtask

  task automatic test_modes();
    check_mode(1'b0, 1'b0, 1'b0, 0);
    check_mode(1'b0, 1'b1, 1'b0, 1);
    check_mode(1'b0, 1'b1, 1'b1, 2);
    check_mode(1'b1, 1'b1, 1'b1, 3);
    $display("test_modes done");
  endtask

  task automatic test_live_update();
    logic [DATA_W-1:0] rd;
    logic              err;
    // Dual mode is active; a new code must reach core A unchanged
    cur[6] = 8'h81;
    apb(1'b1, addr_of(6), 32'h0000_0081, 4'h1, rd, err);
    repeat (2) @(posedge clk_sys);
    #1;
    check("core_a_delay", {24'h0, core_delay[0]}, 32'h0000_0081);
    // Frozen clock enable must hold core A delay across a mode change
    @(posedge clk_sys);
    ce        <= 1'b0;
    mode_dual <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check("core_a_frozen", {24'h0, core_delay[0]}, 32'h0000_0081);
    @(posedge clk_sys);
    ce <= 1'b1;
    check_mode(1'b0, 1'b1, 1'b0, 1);
    check_mode(1'b0, 1'b0, 1'b0, 0);
    check_mode(1'b0, 1'b1, 1'b1, 2);
    $display("test_live_update done");
  endtask

  task automatic test_reset_reload();
    sitb_trims_t ft;
    // A second reset must replace software values with fresh factory trims
    for (int k = 0; k < NUM_TRIM; k++) begin
      cur[k] = 8'h10 + TRIM_W'(k * 3);
      ft[k]  = cur[k];
    end
    @(posedge clk_sys);
    reset_n      <= 1'b0;
    factory_trim <= ft;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < NUM_TRIM; k++) check_reg(k, {24'h0, cur[k]});
    check_mode(1'b0, 1'b1, 1'b1, 2);
    $display("test_reset_reload done");
  endtask

  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    mode_dual = 1'b0;
    cal_background = 1'b0;
    cal_phase90 = 1'b0;
    for (int k = 0; k < NUM_TRIM; k++) begin
      cur[k] = 8'hA1 + TRIM_W'(k * 7);
      factory_trim[k] = cur[k];
    end
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    test_factory();
    test_write_read();
    test_errors();
    test_modes();
    test_live_update();
    test_reset_reload();
    end_sim();
  end
endmodule
